/* File: src/hpirs_seq.sv */
// host-port 16-bit read access sequencer, multiplexed and simplex variants
// assumes bus_clk, bus_ready_in_n and bus_data_in come from outside the clk domain
// Function
// - address driven with select, valid 11-45 cycles
// - strobe falls 3-4 cycles after select
// - strobe pulse lasts 4-5 cycles
// - data captured 4-5 cycles after strobe falls
// - recovery gap 2-17 cycles between accesses
// - all counts in bus clock cycles
// - setup length held at least minimum
// - strobe length held at least minimum
// - stall extends access, one clock after release
// - recovery length sets idle gap
// - simplex uses the write strobe and ready, read strobe held high
`timescale 1ns/1ps
`default_nettype none
module hpirs_seq
   import hpirs_pkg::*;
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              reset_n,
   // request side
   input  wire logic              req_valid,
   input  wire logic [ADDR_W-1:0] req_addr,
   input  wire logic              simplex_mode,
   input  wire logic [CNT_W-1:0]  setup_phase_length,
   input  wire logic [CNT_W-1:0]  strobe_phase_length,
   input  wire logic [CNT_W-1:0]  recovery_phase_length,
   output logic                   busy,
   output logic                   rd_done,
   output logic [DATA_W-1:0]      rd_data,
   // expansion bus pins
   input  wire logic              bus_clk,
   input  wire logic              bus_ready_in_n,
   input  wire logic [DATA_W-1:0] bus_data_in,
   output logic                   bus_select_n,
   output logic [ADDR_W-1:0]      bus_addr_out,
   output logic                   bus_addr_oe,
   output logic                   host_data_strobe_n,
   output logic                   host_read_write_select,
   output logic                   bus_read_strobe_n,
   output logic                   bus_write_strobe_n
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [CNT_W-1:0] clamp_len(input logic [CNT_W-1:0] v,
                                                  input logic [CNT_W-1:0] lo,
                                                  input logic [CNT_W-1:0] hi);
      clamp_len = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [2:0]        bclk_ff;
   logic [1:0]        rdy_ff;
   logic [DATA_W-1:0] din1_ff;
   logic [DATA_W-1:0] din2_ff;
   logic              tick;
   logic              stall;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bclk_ff <= '0;
         rdy_ff  <= 2'h3;
         din1_ff <= '0;
         din2_ff <= '0;
      end else begin
         bclk_ff <= {bclk_ff[1:0], bus_clk};
         rdy_ff  <= {rdy_ff[0], bus_ready_in_n};
         din1_ff <= bus_data_in;
         din2_ff <= din1_ff;
      end
   end

   // one tick per rising bus clock edge; the edge detector only reads stages 2 and 3
   assign tick  = bclk_ff[1] & ~bclk_ff[2];
   // ready high means the slave is still busy
   assign stall = rdy_ff[1];

   // ------------------------------------------------------------
   // phase counter
   // ------------------------------------------------------------
   hpirs_cnt_if cnt_if ();

   hpirs_phase_cnt u_cnt (
      .clk     (clk),
      .reset_n (reset_n),
      .c       (cnt_if.cnt)
   );

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   hpirs_state_t      state_ff,   nxt_state;
   logic [ADDR_W-1:0] addr_ff,    nxt_addr;
   logic              simplex_ff, nxt_simplex;
   logic [CNT_W-1:0]  setup_ff,   nxt_setup;
   logic [CNT_W-1:0]  strobe_ff,  nxt_strobe;
   logic [CNT_W-1:0]  recov_ff,   nxt_recov;
   logic              stalled_ff, nxt_stalled;
   logic              stb_ff,     nxt_stb;
   logic              sel_ff,     nxt_sel;
   logic              busy_ff,    nxt_busy;
   logic              done_ff,    nxt_done;
   logic [DATA_W-1:0] data_ff,    nxt_data;
   logic              load;
   logic [CNT_W-1:0]  load_val;
   logic              hold;

   always_comb begin
      nxt_state   = state_ff;
      nxt_addr    = addr_ff;
      nxt_simplex = simplex_ff;
      nxt_setup   = setup_ff;
      nxt_strobe  = strobe_ff;
      nxt_recov   = recov_ff;
      nxt_stalled = stalled_ff;
      nxt_stb     = stb_ff;
      nxt_sel     = sel_ff;
      nxt_busy    = busy_ff;
      nxt_done    = 1'b0;
      nxt_data    = data_ff;
      load        = 1'b0;
      load_val    = '0;
      hold        = 1'b0;
      case (state_ff)
         ST_IDLE: begin
            if (req_valid) begin
               nxt_addr    = req_addr;
               nxt_simplex = simplex_mode;
               nxt_setup   = clamp_len(setup_phase_length, SETUP_MIN, SETUP_MAX);
               nxt_strobe  = clamp_len(strobe_phase_length, STROBE_MIN, STROBE_MAX);
               nxt_recov   = clamp_len(recovery_phase_length, RECOV_MIN, RECOV_MAX);
               nxt_busy    = 1'b1;
               nxt_state   = ST_LAUNCH;
            end
         end
         ST_LAUNCH: begin
            // wait for a bus clock edge so select lines up with it
            if (tick) begin
               nxt_sel   = 1'b1;
               load      = 1'b1;
               load_val  = setup_ff - 5'h01;
               nxt_state = ST_SETUP;
            end
         end
         ST_SETUP: begin
            if (tick && cnt_if.zero) begin
               nxt_stb     = 1'b1;
               nxt_stalled = 1'b0;
               load        = 1'b1;
               load_val    = strobe_ff - 5'h01;
               nxt_state   = ST_STROBE;
            end
         end
         ST_STROBE: begin
            hold = stall;
            if (tick) begin
               if (stall) begin
                  nxt_stalled = 1'b1;
               end else if (stalled_ff) begin
                  // released: spend one more clock before capture
                  nxt_stalled = 1'b0;
               end else if (cnt_if.zero) begin
                  nxt_data  = din2_ff;
                  nxt_done  = 1'b1;
                  nxt_stb   = 1'b0;
                  load      = 1'b1;
                  load_val  = HOLD_TICKS - 5'h01;
                  nxt_state = ST_HOLD;
               end
            end
         end
         ST_HOLD: begin
            if (tick && cnt_if.zero) begin
               nxt_sel   = 1'b0;
               load      = 1'b1;
               load_val  = recov_ff - 5'h01;
               nxt_state = ST_RECOV;
            end
         end
         ST_RECOV: begin
            if (tick && cnt_if.zero) begin
               nxt_busy  = 1'b0;
               nxt_state = ST_IDLE;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff   <= ST_IDLE;
         addr_ff    <= '0;
         simplex_ff <= 1'b0;
         setup_ff   <= SETUP_MIN;
         strobe_ff  <= STROBE_MIN;
         recov_ff   <= RECOV_MIN;
         stalled_ff <= 1'b0;
         stb_ff     <= 1'b0;
         sel_ff     <= 1'b0;
         busy_ff    <= 1'b0;
         done_ff    <= 1'b0;
         data_ff    <= '0;
      end else begin
         state_ff   <= nxt_state;
         addr_ff    <= nxt_addr;
         simplex_ff <= nxt_simplex;
         setup_ff   <= nxt_setup;
         strobe_ff  <= nxt_strobe;
         recov_ff   <= nxt_recov;
         stalled_ff <= nxt_stalled;
         stb_ff     <= nxt_stb;
         sel_ff     <= nxt_sel;
         busy_ff    <= nxt_busy;
         done_ff    <= nxt_done;
         data_ff    <= nxt_data;
      end
   end

   assign cnt_if.load     = load;
   assign cnt_if.load_val = load_val;
   assign cnt_if.tick     = tick;
   assign cnt_if.hold     = hold;

   // ------------------------------------------------------------
   // pin drive from flip-flops, strobes gated by simplex_ff, read pins tied high
   // ------------------------------------------------------------
   assign busy                   = busy_ff;
   assign rd_done                = done_ff;
   assign rd_data                = data_ff;
   assign bus_select_n           = ~sel_ff;
   assign bus_addr_out           = addr_ff;
   assign bus_addr_oe            = sel_ff;
   // multiplexed: dedicated strobe; simplex: write strobe carries it
   assign host_data_strobe_n     = ~(stb_ff & ~simplex_ff);
   assign bus_write_strobe_n     = ~(stb_ff & simplex_ff);
   // read select held high (read) in both variants
   assign host_read_write_select = 1'b1;
   assign bus_read_strobe_n      = 1'b1;

   // ------------------------------------------------------------
   // checks, counted in bus clock ticks
   // ------------------------------------------------------------
   logic [MON_W-1:0] sel_ticks_ff, nxt_sel_ticks;
   logic [MON_W-1:0] stb_ticks_ff, nxt_stb_ticks;
   logic [MON_W-1:0] gap_ticks_ff, nxt_gap_ticks;
   logic             stall_seen_ff, nxt_stall_seen;

   always_comb begin
      nxt_sel_ticks  = sel_ff ? sel_ticks_ff + MON_W'(tick) : '0;
      nxt_stb_ticks  = stb_ff ? stb_ticks_ff + MON_W'(tick) : '0;
      nxt_gap_ticks  = (!sel_ff && tick && gap_ticks_ff != MON_SAT) ?
                       gap_ticks_ff + 6'h01 : (sel_ff ? 6'h00 : gap_ticks_ff);
      nxt_stall_seen = stb_ff ? (stall_seen_ff | stalled_ff) : 1'b0;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sel_ticks_ff  <= '0;
         stb_ticks_ff  <= '0;
         gap_ticks_ff  <= MON_SAT;
         stall_seen_ff <= 1'b0;
      end else begin
         sel_ticks_ff  <= nxt_sel_ticks;
         stb_ticks_ff  <= nxt_stb_ticks;
         gap_ticks_ff  <= nxt_gap_ticks;
         stall_seen_ff <= nxt_stall_seen;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence access_end_s;
      $rose(bus_select_n);
   endsequence
   sequence strobe_end_s;
      $fell(stb_ff) ##0 !stall_seen_ff;
   endsequence

   addr_valid_a:   assert property (access_end_s |-> sel_ticks_ff >= ADDR_MIN &&
                                    (stall_seen_ff || sel_ticks_ff <= ADDR_MAX))
      else $error("address valid time out of range");
   addr_with_sel_a: assert property ($fell(bus_select_n) |-> bus_addr_oe &&
                                     bus_addr_out == $past(addr_ff))
      else $error("address not driven with select");
   sel_to_stb_a:   assert property ($rose(stb_ff) |-> sel_ticks_ff == {1'b0, setup_ff} &&
                                    sel_ticks_ff >= 6'h03 && sel_ticks_ff <= 6'h04)
      else $error("select to strobe delay wrong");
   strobe_width_a: assert property (strobe_end_s |-> stb_ticks_ff >= 6'h04 &&
                                    stb_ticks_ff <= 6'h05)
      else $error("strobe pulse width wrong");
   capture_point_a: assert property (nxt_done |-> stb_ticks_ff + 6'h01 >= 6'h04 &&
                                     (stall_seen_ff || stalled_ff ||
                                      stb_ticks_ff + 6'h01 <= 6'h05))
      else $error("read data captured outside window");
   recov_gap_a:    assert property ($fell(bus_select_n) |-> gap_ticks_ff >= 6'h02)
      else $error("recovery gap too short");
   tick_only_a:    assert property ($changed(stb_ff) || $changed(sel_ff) |-> $past(tick))
      else $error("pin changed without a bus clock edge");
   setup_min_a:    assert property (setup_ff >= SETUP_MIN)
      else $error("setup length below minimum");
   strobe_min_a:   assert property (strobe_ff >= STROBE_MIN)
      else $error("strobe length below minimum");
   stall_ext_a:    assert property ((state_ff == ST_STROBE && tick && stall) |=>
                                    state_ff == ST_STROBE ##0 stalled_ff)
      else $error("access not extended by stall");
   recov_len_a:    assert property ((state_ff == ST_RECOV) ##1 (state_ff == ST_IDLE) |->
                                    gap_ticks_ff == {1'b0, recov_ff})
      else $error("recovery length not honoured");
   simplex_pins_a: assert property (stb_ff |-> (simplex_ff ? (!bus_write_strobe_n &&
                                    host_data_strobe_n) : (bus_write_strobe_n &&
                                    !host_data_strobe_n)))
      else $error("strobe routed to wrong pin");
endmodule // hpirs_seq
`default_nettype wire

/* File: src/hpirs_pkg.sv */
// constants for the host-port read access sequencer
// assumes one bus clock tick is found by sampling the bus clock pin on clk
package hpirs_pkg;
   // ------------------------------------------------------------
   // widths
   // ------------------------------------------------------------
   localparam int ADDR_W = 24;
   localparam int DATA_W = 16;
   localparam int CNT_W  = 5;
   localparam int MON_W  = 6;

   // ------------------------------------------------------------
   // phase lengths in bus clock cycles
   // ------------------------------------------------------------
   localparam logic [CNT_W-1:0] SETUP_MIN   = 5'h03;
   localparam logic [CNT_W-1:0] SETUP_MAX   = 5'h04;
   localparam logic [CNT_W-1:0] STROBE_MIN  = 5'h04;
   localparam logic [CNT_W-1:0] STROBE_MAX  = 5'h05;
   localparam logic [CNT_W-1:0] HOLD_TICKS  = 5'h04;
   localparam logic [CNT_W-1:0] RECOV_MIN   = 5'h02;
   localparam logic [CNT_W-1:0] RECOV_MAX   = 5'h11;
   localparam logic [MON_W-1:0] ADDR_MIN    = 6'h0B;
   localparam logic [MON_W-1:0] ADDR_MAX    = 6'h2D;
   localparam logic [MON_W-1:0] MON_SAT     = 6'h3F;

   // ------------------------------------------------------------
   // sequencer states
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_LAUNCH,
      ST_SETUP,
      ST_STROBE,
      ST_HOLD,
      ST_RECOV
   } hpirs_state_t;
endpackage

/* File: src/hpirs_cnt_if.sv */
// bundle between the sequencer and its phase down-counter
// assumes both ends share clk and reset_n
`timescale 1ns/1ps
`default_nettype none
interface hpirs_cnt_if;
   logic       load;
   logic [4:0] load_val;
   logic       tick;
   logic       hold;
   logic [4:0] count;
   logic       zero;
   modport ctl (output load, output load_val, output tick, output hold,
                input count, input zero);
   modport cnt (input load, input load_val, input tick, input hold,
                output count, output zero);
endinterface
`default_nettype wire

/* File: src/hpirs_phase_cnt.sv */
// loadable phase down-counter, steps once per bus clock tick
// assumes load and tick come from logic on clk
`timescale 1ns/1ps
`default_nettype none
module hpirs_phase_cnt
   import hpirs_pkg::*;
(
   // clock and reset
   input  wire logic     clk,
   input  wire logic     reset_n,
   // control side
   hpirs_cnt_if.cnt      c
);
   logic [CNT_W-1:0] count_ff;
   logic [CNT_W-1:0] nxt_count;

   always_comb begin
      nxt_count = count_ff;
      if (c.load) begin
         nxt_count = c.load_val;
      end else if (c.tick && !c.hold && count_ff != '0) begin
         nxt_count = count_ff - 5'h01;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         count_ff <= '0;
      end else begin
         count_ff <= nxt_count;
      end
   end

   assign c.count = count_ff;
   assign c.zero  = (count_ff == '0);

   property step_down_p;
      @(posedge clk) disable iff (!reset_n)
      (c.tick && !c.load && !c.hold && count_ff != '0) |=> count_ff == $past(count_ff) - 5'h01;
   endproperty
   cnt_step_down_a: assert property (step_down_p)
      else $error("phase counter did not step down on a tick");
endmodule // hpirs_phase_cnt
`default_nettype wire

/* File: tb/hpirs_slave_model.sv */
// host port slave model: answers each read with an address-derived word
// assumes strobes and select come straight from the sequencer pins
`timescale 1ns/1ps
`default_nettype none
module hpirs_slave_model
   import hpirs_pkg::*;
(
   // link side
   input  wire logic              bus_clk,
   input  wire logic              bus_select_n,
   input  wire logic [ADDR_W-1:0] bus_addr_out,
   input  wire logic              host_data_strobe_n,
   input  wire logic              bus_write_strobe_n,
   output logic                   bus_ready_in_n,
   output logic [DATA_W-1:0]      bus_data_in,
   // bench control
   input  wire logic              simplex_mode,
   input  wire logic [3:0]        stall_ticks
);
   logic              stb_n;
   logic [3:0]        waited;
   logic              ok;
   logic [DATA_W-1:0] word;

   assign stb_n = simplex_mode ? bus_write_strobe_n : host_data_strobe_n;
   assign word  = bus_addr_out[DATA_W-1:0] ^ 16'h5A3C;
   // the first bus clock edge in the strobe is seen with the first tick, so stall_ticks
   // stalled ticks need the word held back until one edge more than that
   assign ok    = !stb_n && (waited > stall_ticks);

   always @(posedge bus_clk or posedge stb_n) begin
      if (stb_n)
         waited <= 4'h0;
      else if (waited <= stall_ticks)
         waited <= waited + 4'h1;
   end

   // not ready means the word is not there yet: inverse, never a stale copy
   assign bus_ready_in_n = bus_select_n | !ok;
   assign bus_data_in    = ok ? word : ~word;
endmodule // hpirs_slave_model
`default_nettype wire

/* File: tb/hpirs_seq_tb.sv */
// self-checking bench for the host-port read sequencer
// assumes hpirs_seq and the slave model; times are counted in bus clock ticks
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fail_count++; \
   $display("mismatch at %0t: got %h exp %h", $time, (a), (e)); end end
module hpirs_seq_tb;
   import hpirs_pkg::*;
   logic              clk, reset_n, bus_clk, req_valid, simplex_mode, busy, rd_done;
   logic [ADDR_W-1:0] req_addr, bus_addr_out, cur_addr;
   logic [CNT_W-1:0]  setup_phase_length, strobe_phase_length, recovery_phase_length;
   logic [DATA_W-1:0] rd_data, bus_data_in, got;
   logic              bus_ready_in_n, bus_select_n, bus_addr_oe, host_data_strobe_n;
   logic              host_read_write_select, bus_read_strobe_n, bus_write_strobe_n;
   logic              cur_mode, sel_q, stb_q, stb, got_done;
   logic [3:0]        stall_ticks;
   int                fail_count, checks_done, tick, t_sf, t_sr, t_bf, t_br, gap, n_acc;

   hpirs_seq hpirs_seq_i (.clk(clk), .reset_n(reset_n), .req_valid(req_valid),
      .req_addr(req_addr), .simplex_mode(simplex_mode), .setup_phase_length(setup_phase_length),
      .strobe_phase_length(strobe_phase_length), .recovery_phase_length(recovery_phase_length),
      .busy(busy), .rd_done(rd_done), .rd_data(rd_data), .bus_clk(bus_clk),
      .bus_ready_in_n(bus_ready_in_n), .bus_data_in(bus_data_in), .bus_select_n(bus_select_n),
      .bus_addr_out(bus_addr_out), .bus_addr_oe(bus_addr_oe),
      .host_data_strobe_n(host_data_strobe_n), .host_read_write_select(host_read_write_select),
      .bus_read_strobe_n(bus_read_strobe_n), .bus_write_strobe_n(bus_write_strobe_n));

   hpirs_slave_model hpirs_slave_model_i (.bus_clk(bus_clk), .bus_select_n(bus_select_n),
      .bus_addr_out(bus_addr_out), .host_data_strobe_n(host_data_strobe_n),
      .bus_write_strobe_n(bus_write_strobe_n), .bus_ready_in_n(bus_ready_in_n),
      .bus_data_in(bus_data_in), .simplex_mode(cur_mode), .stall_ticks(stall_ticks));

   // ------------------------------------------------------------
   // clocks and edge monitor
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // bus clock phase kept unrelated to clk
   initial begin
      bus_clk = 1'b0;
      #7;
      forever #160 bus_clk = ~bus_clk;
   end
   always @(posedge bus_clk) tick++;

   assign stb = cur_mode ? bus_write_strobe_n : host_data_strobe_n;
   always @(posedge clk) begin
      sel_q <= bus_select_n;
      stb_q <= stb;
      if (sel_q === 1'b1 && bus_select_n === 1'b0) begin
         t_sf  <= tick;
         gap   <= tick - t_sr;
         n_acc <= n_acc + 1;
      end
      if (sel_q === 1'b0 && bus_select_n === 1'b1) t_sr <= tick;
      if (stb_q === 1'b1 && stb === 1'b0) t_bf <= tick;
      if (stb_q === 1'b0 && stb === 1'b1) t_br <= tick;
      if (reset_n === 1'b1) begin
         if (bus_select_n === 1'b0) `CHK({bus_addr_oe, bus_addr_out}, {1'b1, cur_addr})
         `CHK({bus_read_strobe_n, host_read_write_select}, 2'h3)
         `CHK(cur_mode ? host_data_strobe_n : bus_write_strobe_n, 1'b1)
      end
   end

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   function automatic int clampv(input int v, input int lo, input int hi);
      return (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   task automatic conclude();
      if (fail_count == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // one read; hold_req keeps requesting another address until rd_done is seen
   task automatic access(input logic [ADDR_W-1:0] a, input logic m, input int su, input int st,
                         input int rc, input logic hold_req);
      int n;
      n = 0;
      @(posedge clk);
      req_valid             <= 1'b1;
      req_addr              <= a;
      simplex_mode          <= m;
      setup_phase_length    <= su[CNT_W-1:0];
      strobe_phase_length   <= st[CNT_W-1:0];
      recovery_phase_length <= rc[CNT_W-1:0];
      cur_mode              <= m;
      cur_addr              <= a;
      do begin
         @(negedge clk);
         n++;
      end while (busy !== 1'b1 && n < 4);
      @(posedge clk);
      if (hold_req) req_addr <= ~a;
      else req_valid <= 1'b0;
      got_done = 1'b0;
      n = 0;
      while (busy !== 1'b0 && n < 3000) begin
         @(negedge clk);
         if (rd_done === 1'b1) begin
            got_done = 1'b1;
            got      = rd_data;
            if (hold_req) req_valid <= 1'b0;
         end
         n++;
      end
      `CHK({got_done, got}, {1'b1, a[DATA_W-1:0] ^ 16'h5A3C})
      `CHK(t_bf - t_sf, clampv(su, 3, 4))
      `CHK(t_sr - t_sf, clampv(su, 3, 4) + clampv(st, 4, 5) + 4 + (t_br - t_bf - clampv(st, 4, 5)))
      `CHK(t_sr - t_sf >= 11 && (stall_ticks != 0 || t_sr - t_sf <= 45), 1'b1)
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   // lengths below and above the legal ranges are clamped, both variants
   task automatic t_lengths();
      int su[5] = '{0, 3, 4, 31, 7};
      int st[5] = '{1, 4, 5, 31, 9};
      for (int i = 0; i < 5; i++) begin
         access(24'hA1_0000 + i * 24'h1357, i[0], su[i], st[i], 2, 1'b0);
         `CHK(t_br - t_bf, clampv(st[i], 4, 5))
         `CHK(t_bf - t_sf, clampv(su[i], 3, 4))
      end
   endtask

   // back to back at the shortest and the longest recovery
   task automatic t_recovery();
      int rcs[4] = '{0, 2, 17, 31};
      for (int i = 0; i < 4; i++) begin
         access(24'h33_1200 + i, 1'b0, 4, 5, rcs[i], 1'b0);
         access(24'h44_0F00 + i, 1'b1, 3, 4, 2, 1'b0);
         `CHK(gap >= clampv(rcs[i], 2, 17) && gap <= clampv(rcs[i], 2, 17) + 2, 1'b1)
      end
   endtask

   // slave stalls with late data; request held high while busy is refused
   task automatic t_stall_refuse();
      int n0;
      n0 = n_acc;
      for (int s = 1; s < 4; s++) begin
         stall_ticks = s[3:0];
         access(24'h5C_0000 + s, s[0], 4, 4, 2, 1'b1);
         `CHK(t_br - t_bf >= 4 + s && t_br - t_bf <= 6 + s, 1'b1)
      end
      stall_ticks = 4'h0;
      `CHK(n_acc - n0, 3)
   endtask

   // reset in mid access returns every pin to idle
   task automatic t_reset_mid();
      int n;
      n = 0;
      @(posedge clk);
      req_valid <= 1'b1;
      req_addr  <= 24'h12_3456;
      cur_addr  <= 24'h12_3456;
      cur_mode  <= 1'b0;
      simplex_mode <= 1'b0;
      while (bus_select_n !== 1'b0 && n < 100) begin
         @(negedge clk);
         n++;
      end
      @(posedge clk);
      req_valid <= 1'b0;
      reset_n   <= 1'b0;
      @(negedge clk);
      `CHK({bus_select_n, host_data_strobe_n, bus_write_strobe_n, bus_addr_oe}, 4'hE)
      `CHK({busy, rd_done, rd_data}, 18'h0_0000)
      @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      access(24'h00_FFFF, 1'b1, 3, 5, 17, 1'b0);
   endtask

   // ------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      reset_n = 1'b0;
      req_valid = 1'b0;
      req_addr = '0;
      simplex_mode = 1'b0;
      setup_phase_length = 5'h03;
      strobe_phase_length = 5'h04;
      recovery_phase_length = 5'h02;
      cur_mode = 1'b0;
      cur_addr = '0;
      stall_ticks = 4'h0;
      {fail_count, checks_done, tick, t_sf, t_sr, t_bf, t_br, gap, n_acc} = '0;
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_lengths();
      t_recovery();
      t_stall_refuse();
      t_reset_mid();
      conclude();
   end

   // about eighteen accesses of at most forty ticks each
   initial begin
      #2ms;
      fail_count++;
      conclude();
   end
endmodule // hpirs_seq_tb
`default_nettype wire
